// >>> src/dbs_pkg.sv
/*
  dbs_pkg: widths, link timing, phases and reset values shared by both ends of the
  two-word burst memory link (x18 organisation).
  assumes one 40 MHz system clock at each end and a link clock period of 200 ns.
*/
// Overview of operation
// - address taken on primary input clock rise
// - each transaction moves exactly two words
// - burst-low address bit is lowest address bit
// - strobe high means idle cycle, address ignored
// - write words taken on both input clock rises
// - read data timed by output or input clocks
// - data bus is 9, 18 or 36 bits; 18 bits here
// - host drives strobe low to load transaction
// - direction select high reads, low writes
// - low lane mask stores lane, per word
// - one, two or four lane masks; two here
// - complementary input clock is antiphase to primary
// - first word at complementary, second at primary
// - input-clock reference holds both output clocks high
// - echo clocks free-run, follow source clocks
package dbs_pkg;
    // ==========================================================
    // organisation
    localparam int unsigned DATA_W = 18;
    localparam int unsigned LANES = 2;
    localparam int unsigned LANE_W = 9;
    localparam int unsigned WORDS = 2;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DEPTH = 16;
    localparam logic [ADDR_W-1:0] BURST_FLIP = 4'h1;
    // ==========================================================
    // link timing
    localparam int unsigned SYS_PERIOD_NS = 25;
    localparam int unsigned LINK_PERIOD_NS = 200;
    localparam int unsigned LINK_CYCLES = LINK_PERIOD_NS / SYS_PERIOD_NS;
    localparam int unsigned PH_W = 3;
    localparam logic [PH_W-1:0] K_HIGH_PH = PH_W'(LINK_CYCLES / 2);
    localparam logic [PH_W-1:0] PH_WORD1 = 3'h1;
    localparam logic [PH_W-1:0] PH_ARM = 3'h4;
    localparam logic [PH_W-1:0] PH_READY = 3'h4;
    localparam logic [PH_W-1:0] PH_LOAD = 3'h5;
    localparam int unsigned BUF_DEPTH = 2;
    // ==========================================================
    // reset values
    // phase 7 agrees with k low in reset, so the first k high phase is full length
    localparam logic [PH_W-1:0] RST_PH = 3'h7;
    localparam logic [3:0] RST_CLK_PREV = 4'hf;
    localparam logic [1:0] RST_ECHO = 2'h0;
    localparam logic RST_STROBE_N = 1'h1;
endpackage : dbs_pkg

// >>> src/dbs_link_if.sv
/*
  dbs_link_if: the pins between the host controller and the burst memory.
  assumes the bench or a top joins both modports; the shared data bus is
  resolved here from the two output enables.
*/
`timescale 1ns/100ps
interface dbs_link_if;
    logic k;
    logic k_n;
    logic c;
    logic c_n;
    logic cycle_define_n;
    logic read_sel;
    logic [dbs_pkg::ADDR_W-1:0] addr;
    logic [dbs_pkg::LANES-1:0] lane_write_mask_n;
    logic [1:0] echo_clk_pair;
    logic [dbs_pkg::DATA_W-1:0] host_dq_o;
    logic host_dq_oe;
    logic [dbs_pkg::DATA_W-1:0] sram_dq_o;
    logic sram_dq_oe;
    wire [dbs_pkg::DATA_W-1:0] data_io_bus;

    // ==========================================================
    // bus resolution; overlap would show as the memory winning
    // a released bus shows the inverse host word, so a stale sample is caught
    assign data_io_bus = sram_dq_oe ? sram_dq_o :
                         (host_dq_oe ? host_dq_o : ~host_dq_o);

    modport host (
        output k, k_n, c, c_n, cycle_define_n, read_sel, addr, lane_write_mask_n,
        output host_dq_o, host_dq_oe,
        input echo_clk_pair, data_io_bus
    );
    modport sram (
        input k, k_n, c, c_n, cycle_define_n, read_sel, addr, lane_write_mask_n,
        input data_io_bus,
        output echo_clk_pair, sram_dq_o, sram_dq_oe
    );
endinterface : dbs_link_if

// >>> src/dbs_pair_buffer.sv
/*
  dbs_pair_buffer: small shift-style fifo; head entry is always slot 0 so the
  output data and valid come straight from flip-flops.
  assumes one clock, synchronous active-high reset.
*/
`timescale 1ns/100ps
module dbs_pair_buffer #(
    parameter int unsigned WIDTH = 36,
    parameter int unsigned DEPTH = 2
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    logic [DEPTH-1:0] vld;
    logic [DEPTH-1:0] next_vld;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic pop;
    logic push;

    assign in_ready_out = ~vld[DEPTH-1];
    assign out_valid_out = vld[0];
    assign out_data_out = mem[0];
    assign pop = out_ready_in & vld[0];
    assign push = in_valid_in & ~vld[DEPTH-1];

    // ==========================================================
    // shift on pop, then fill the lowest free slot
    always_comb begin
        logic done;
        done = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            if (pop) begin
                next_vld[i] = (i < DEPTH - 1) ? vld[(i + 1) % DEPTH] : 1'b0;
                next_mem[i] = mem[(i + 1) % DEPTH];
            end else begin
                next_vld[i] = vld[i];
                next_mem[i] = mem[i];
            end
        end
        for (int i = 0; i < DEPTH; i++) begin
            if (push && !next_vld[i] && !done) begin
                next_vld[i] = 1'b1;
                next_mem[i] = in_data_in;
                done = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            vld <= '0;
        end else begin
            vld <= next_vld;
        end
        mem <= next_mem;
    end
endmodule : dbs_pair_buffer

// >>> src/dbs_sram_end.sv
/*
  dbs_sram_end: the burst memory end of the link, a 16 x 18 store in flip-flops.
  assumes every link pin is asynchronous to sys_clk_in and much slower than it;
  all pins pass the same two-flop path so their relative timing is kept.
*/
`timescale 1ns/100ps
module dbs_sram_end (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    dbs_link_if.sram link,
    output logic idle_cycle_out,
    output logic k_ref_mode_out
);
    typedef enum logic [1:0] {OUT_IDLE, OUT_FIRST, OUT_SECOND} dbs_out_state_t;

    localparam int unsigned SYNC_W = 6 + dbs_pkg::ADDR_W + dbs_pkg::LANES + dbs_pkg::DATA_W;

    // ==========================================================
    // pin synchronisers
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    logic [3:0] clk_prev;
    logic k_s;
    logic k_n_s;
    logic c_s;
    logic c_n_s;
    logic ld_n_s;
    logic read_s;
    logic [dbs_pkg::ADDR_W-1:0] addr_s;
    logic [dbs_pkg::LANES-1:0] mask_s;
    logic [dbs_pkg::DATA_W-1:0] dq_s;
    logic k_rise;
    logic k_n_rise;
    logic c_rise;
    logic c_n_rise;
    logic ref_k;
    logic first_edge;
    logic second_edge;

    always_ff @(posedge sys_clk_in) begin
        sync_a <= {link.k, link.k_n, link.c, link.c_n, link.cycle_define_n,
                   link.read_sel, link.addr, link.lane_write_mask_n, link.data_io_bus};
        sync_b <= sync_a;
        if (rst_in) begin
            clk_prev <= dbs_pkg::RST_CLK_PREV;
        end else begin
            clk_prev <= sync_b[SYNC_W-1 -: 4];
        end
    end

    assign {k_s, k_n_s, c_s, c_n_s, ld_n_s, read_s, addr_s, mask_s, dq_s} = sync_b;
    assign k_rise = k_s & ~clk_prev[3];
    assign k_n_rise = k_n_s & ~clk_prev[2];
    assign c_rise = c_s & ~clk_prev[1];
    assign c_n_rise = c_n_s & ~clk_prev[0];
    // both output clocks high means read timing falls back to the input pair
    assign ref_k = c_s & c_n_s;
    assign first_edge = ref_k ? k_n_rise : c_n_rise;
    assign second_edge = ref_k ? k_rise : c_rise;

    // ==========================================================
    // transaction state
    logic [dbs_pkg::DATA_W-1:0] mem [dbs_pkg::DEPTH];
    logic [dbs_pkg::DATA_W-1:0] next_mem [dbs_pkg::DEPTH];
    logic wr_pend;
    logic next_wr_pend;
    logic [dbs_pkg::ADDR_W-1:0] wr_addr;
    logic [dbs_pkg::ADDR_W-1:0] next_wr_addr;
    logic [dbs_pkg::DATA_W-1:0] wr_word0;
    logic [dbs_pkg::DATA_W-1:0] next_wr_word0;
    logic [dbs_pkg::LANES-1:0] wr_mask0;
    logic [dbs_pkg::LANES-1:0] next_wr_mask0;
    logic rd_pend;
    logic next_rd_pend;
    logic [dbs_pkg::DATA_W-1:0] rd_word0;
    logic [dbs_pkg::DATA_W-1:0] next_rd_word0;
    logic [dbs_pkg::DATA_W-1:0] rd_word1;
    logic [dbs_pkg::DATA_W-1:0] next_rd_word1;
    dbs_out_state_t out_state;
    dbs_out_state_t next_out_state;
    logic [dbs_pkg::DATA_W-1:0] dq_o;
    logic [dbs_pkg::DATA_W-1:0] next_dq_o;
    logic dq_oe;
    logic next_dq_oe;
    logic [1:0] echo;
    logic [1:0] next_echo;
    logic idle_cycle;
    logic next_idle_cycle;
    logic k_ref;
    logic next_k_ref;

    always_comb begin
        next_mem = mem;
        next_wr_pend = wr_pend;
        next_wr_addr = wr_addr;
        next_wr_word0 = wr_word0;
        next_wr_mask0 = wr_mask0;
        next_rd_pend = rd_pend;
        next_rd_word0 = rd_word0;
        next_rd_word1 = rd_word1;
        next_out_state = out_state;
        next_dq_o = dq_o;
        next_dq_oe = dq_oe;
        next_idle_cycle = idle_cycle;
        next_k_ref = ref_k;

        // address, direction and first write word on the primary rise
        if (k_rise) begin
            next_idle_cycle = ld_n_s;
            next_wr_pend = 1'b0;
            if (!ld_n_s) begin
                if (read_s) begin
                    // snapshot both words now; a later write cannot tear the pair
                    next_rd_pend = 1'b1;
                    next_rd_word0 = mem[addr_s];
                    next_rd_word1 = mem[addr_s ^ dbs_pkg::BURST_FLIP];
                end else begin
                    next_wr_pend = 1'b1;
                    next_wr_addr = addr_s;
                    next_wr_word0 = dq_s;
                    next_wr_mask0 = mask_s;
                end
            end
        end

        // second write word on the complementary rise, then commit the pair
        if (k_n_rise && wr_pend) begin
            next_wr_pend = 1'b0;
            for (int l = 0; l < dbs_pkg::LANES; l++) begin
                if (!wr_mask0[l]) begin
                    next_mem[wr_addr][l*dbs_pkg::LANE_W +: dbs_pkg::LANE_W] =
                        wr_word0[l*dbs_pkg::LANE_W +: dbs_pkg::LANE_W];
                end
                if (!mask_s[l]) begin
                    next_mem[wr_addr ^ dbs_pkg::BURST_FLIP][l*dbs_pkg::LANE_W +: dbs_pkg::LANE_W] =
                        dq_s[l*dbs_pkg::LANE_W +: dbs_pkg::LANE_W];
                end
            end
        end

        // read words launched on the reference pair
        case (out_state)
            OUT_IDLE, OUT_SECOND: begin
                if (first_edge) begin
                    if (rd_pend) begin
                        next_dq_o = rd_word0;
                        next_dq_oe = 1'b1;
                        next_rd_pend = 1'b0;
                        next_out_state = OUT_FIRST;
                    end else begin
                        next_dq_oe = 1'b0;
                        next_out_state = OUT_IDLE;
                    end
                end
            end
            OUT_FIRST: begin
                if (second_edge) begin
                    next_dq_o = rd_word1;
                    next_out_state = OUT_SECOND;
                end
            end
            default: begin
                next_dq_oe = 1'b0;
                next_out_state = OUT_IDLE;
            end
        endcase

        // echo follows its source level, so it stops only when that source stops
        next_echo = ref_k ? {k_s, k_n_s} : {c_s, c_n_s};
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
            wr_word0 <= '0;
            wr_mask0 <= '1;
            rd_pend <= 1'b0;
            rd_word0 <= '0;
            rd_word1 <= '0;
            out_state <= OUT_IDLE;
            dq_o <= '0;
            dq_oe <= 1'b0;
            echo <= dbs_pkg::RST_ECHO;
            idle_cycle <= dbs_pkg::RST_STROBE_N;
            k_ref <= 1'b0;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            wr_word0 <= next_wr_word0;
            wr_mask0 <= next_wr_mask0;
            rd_pend <= next_rd_pend;
            rd_word0 <= next_rd_word0;
            rd_word1 <= next_rd_word1;
            out_state <= next_out_state;
            dq_o <= next_dq_o;
            dq_oe <= next_dq_oe;
            echo <= next_echo;
            idle_cycle <= next_idle_cycle;
            k_ref <= next_k_ref;
        end
    end

    // the store has no reset, like the part it stands for
    always_ff @(posedge sys_clk_in) begin
        mem <= next_mem;
    end

    // ==========================================================
    // pins and status
    assign link.sram_dq_o = dq_o;
    assign link.sram_dq_oe = dq_oe;
    assign link.echo_clk_pair = echo;
    assign idle_cycle_out = idle_cycle;
    assign k_ref_mode_out = k_ref;
endmodule : dbs_sram_end

// >>> src/dbs_host_end.sv
/*
  dbs_host_end: host controller end; makes the input clock pair by dividing
  sys_clk_in, loads one burst per link period and returns read pairs through a
  two-entry buffer.
  assumes user ports are on sys_clk_in; echo clocks and bus data are not.
*/
`timescale 1ns/100ps
module dbs_host_end (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic use_k_ref_in,
    input wire logic cmd_valid_in,
    output logic cmd_ready_out,
    input wire logic cmd_write_in,
    input wire logic [dbs_pkg::ADDR_W-1:0] cmd_addr_in,
    input wire logic [2*dbs_pkg::DATA_W-1:0] cmd_wdata_in,
    input wire logic [2*dbs_pkg::LANES-1:0] cmd_mask_n_in,
    output logic rd_valid_out,
    input wire logic rd_ready_in,
    output logic [2*dbs_pkg::DATA_W-1:0] rd_data_out,
    dbs_link_if.host link
);
    localparam int unsigned DW = dbs_pkg::DATA_W;

    // ==========================================================
    // echo and bus synchronisers
    logic [DW+1:0] sync_a;
    logic [DW+1:0] sync_b;
    logic [1:0] echo_prev;
    logic cq_rise;
    logic cq_n_rise;

    always_ff @(posedge sys_clk_in) begin
        sync_a <= {link.echo_clk_pair, link.data_io_bus};
        sync_b <= sync_a;
        if (rst_in) begin
            echo_prev <= dbs_pkg::RST_ECHO;
        end else begin
            echo_prev <= sync_b[DW+1:DW];
        end
    end

    assign cq_rise = sync_b[DW+1] & ~echo_prev[1];
    assign cq_n_rise = sync_b[DW] & ~echo_prev[0];

    // ==========================================================
    // link sequencing
    logic [dbs_pkg::PH_W-1:0] ph, next_ph;
    logic k, next_k, c, next_c, c_n, next_c_n;
    logic ld_n, next_ld_n, rsel, next_rsel;
    logic [dbs_pkg::ADDR_W-1:0] addr, next_addr;
    logic [dbs_pkg::LANES-1:0] mask, next_mask, mask1, next_mask1;
    logic [DW-1:0] dq_o, next_dq_o, word1, next_word1, cap0, next_cap0;
    logic dq_oe, next_dq_oe, ready, next_ready;
    logic rd_busy, next_rd_busy, armed, next_armed, have0, next_have0;
    logic push, next_push;
    logic buf_ready;
    logic take;

    assign take = (ph == dbs_pkg::PH_LOAD) & cmd_valid_in & ready;

    always_comb begin
        next_ph = ph + 3'h1;
        // divider: primary high for the first half, complement antiphase
        next_k = (next_ph < dbs_pkg::K_HIGH_PH);
        next_c = use_k_ref_in | next_k;
        next_c_n = use_k_ref_in | ~next_k;
        next_ld_n = ld_n;
        next_rsel = rsel;
        next_addr = addr;
        next_mask = mask;
        next_mask1 = mask1;
        next_dq_o = dq_o;
        next_dq_oe = dq_oe;
        next_word1 = word1;
        next_rd_busy = rd_busy;
        next_armed = armed;
        next_have0 = have0;
        next_cap0 = cap0;
        next_push = 1'b0;
        if (ph == dbs_pkg::PH_LOAD) begin
            next_ld_n = ~take;
            next_dq_oe = take & cmd_write_in;
            if (take) begin
                next_rsel = ~cmd_write_in;
                next_addr = cmd_addr_in;
                next_dq_o = cmd_wdata_in[DW-1:0];
                next_word1 = cmd_wdata_in[2*DW-1:DW];
                next_mask = cmd_mask_n_in[dbs_pkg::LANES-1:0];
                next_mask1 = cmd_mask_n_in[2*dbs_pkg::LANES-1:dbs_pkg::LANES];
                next_rd_busy = ~cmd_write_in;
            end
        end
        if (ph == dbs_pkg::PH_WORD1 && dq_oe) begin
            next_dq_o = word1;
            next_mask = mask1;
        end
        // arming after our own complementary rise skips stale echo edges
        if (ph == dbs_pkg::PH_ARM && rd_busy) begin
            next_armed = 1'b1;
        end
        if (armed && !have0 && cq_n_rise) begin
            next_have0 = 1'b1;
            next_cap0 = sync_b[DW-1:0];
        end
        if (have0 && cq_rise) begin
            next_push = 1'b1;
            next_have0 = 1'b0;
            next_armed = 1'b0;
            next_rd_busy = 1'b0;
        end
        // one read at a time, and only with buffer room, so nothing is lost
        next_ready = (ph == dbs_pkg::PH_READY) & ~next_rd_busy & buf_ready;
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ph <= dbs_pkg::RST_PH;
            k <= 1'b0;
            c <= 1'b0;
            c_n <= 1'b1;
            ld_n <= dbs_pkg::RST_STROBE_N;
            rsel <= 1'b0;
            addr <= '0;
            mask <= '1;
            mask1 <= '1;
            dq_o <= '0;
            dq_oe <= 1'b0;
            word1 <= '0;
            rd_busy <= 1'b0;
            armed <= 1'b0;
            have0 <= 1'b0;
            cap0 <= '0;
            push <= 1'b0;
            ready <= 1'b0;
        end else begin
            ph <= next_ph;
            k <= next_k;
            c <= next_c;
            c_n <= next_c_n;
            ld_n <= next_ld_n;
            rsel <= next_rsel;
            addr <= next_addr;
            mask <= next_mask;
            mask1 <= next_mask1;
            dq_o <= next_dq_o;
            dq_oe <= next_dq_oe;
            word1 <= next_word1;
            rd_busy <= next_rd_busy;
            armed <= next_armed;
            have0 <= next_have0;
            cap0 <= next_cap0;
            push <= next_push;
            ready <= next_ready;
        end
    end

    // word1 captured in the same cycle it is pushed: data register holds it
    logic [2*DW-1:0] push_data;
    always_ff @(posedge sys_clk_in) begin
        push_data <= {sync_b[DW-1:0], cap0};
    end

    dbs_pair_buffer #(
        .WIDTH(2 * DW),
        .DEPTH(dbs_pkg::BUF_DEPTH)
    ) u_rd_buf (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .in_valid_in(push),
        .in_ready_out(buf_ready),
        .in_data_in(push_data),
        .out_valid_out(rd_valid_out),
        .out_ready_in(rd_ready_in),
        .out_data_out(rd_data_out)
    );

    // ==========================================================
    // pins
    assign link.k = k;
    assign link.k_n = ~k;
    assign link.c = c;
    assign link.c_n = c_n;
    assign link.cycle_define_n = ld_n;
    assign link.read_sel = rsel;
    assign link.addr = addr;
    assign link.lane_write_mask_n = mask;
    assign link.host_dq_o = dq_o;
    assign link.host_dq_oe = dq_oe;
    assign cmd_ready_out = ready;
endmodule : dbs_host_end

// >>> dv/dbs_link_assertions.sv
/*
  dbs_link_assertions: pin-level checks of the two-word burst memory link.
  assumes it sits beside the link interface, on the 40 MHz system clock.
*/
`timescale 1ns/100ps
module dbs_link_assertions (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic k,
    input wire logic k_n,
    input wire logic c,
    input wire logic c_n,
    input wire logic cycle_define_n,
    input wire logic read_sel,
    input wire logic [dbs_pkg::ADDR_W-1:0] addr,
    input wire logic [dbs_pkg::LANES-1:0] lane_write_mask_n,
    input wire logic [1:0] echo_clk_pair,
    input wire logic [dbs_pkg::DATA_W-1:0] host_dq_o,
    input wire logic host_dq_oe,
    input wire logic sram_dq_oe
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // ==========================================================
    // echo activity: a counter, since a stopped echo never shows as an edge
    logic echo_prev;
    logic next_echo_prev;
    logic [3:0] quiet;
    logic [3:0] next_quiet;
    always_comb begin
        next_echo_prev = echo_clk_pair[1];
        next_quiet = (quiet == 4'hf) ? quiet : quiet + 4'h1;
        if (rst_in || echo_clk_pair[1] != echo_prev) begin
            next_quiet = 4'h0;
        end
    end
    always_ff @(posedge sys_clk_in) begin
        echo_prev <= next_echo_prev;
        quiet <= next_quiet;
    end
    // ==========================================================
    // assertions
    k_antiphase_a: assert property (k_n == ~k)
        else $error("input clock pair not in antiphase");
    k_period_a: assert property ($rose(k) |-> k [*4] ##1 !k [*4])
        else $error("input clock period wrong");
    ctrl_stable_a: assert property ($rose(k) |-> $stable({cycle_define_n, read_sel, addr})
        ##1 $stable({cycle_define_n, read_sel, addr}))
        else $error("control moved at input clock rise");
    wdata_stable_a: assert property (host_dq_oe && ($rose(k) || $rose(k_n))
        |-> $stable(host_dq_o) && $stable(lane_write_mask_n))
        else $error("write data moved at clock rise");
    load_hold_a: assert property ($fell(cycle_define_n) |-> !cycle_define_n [*4])
        else $error("load strobe too short");
    write_dir_a: assert property ($rose(host_dq_oe) |-> !cycle_define_n && !read_sel)
        else $error("host drove bus outside a write");
    single_driver_a: assert property (!(host_dq_oe && sram_dq_oe))
        else $error("both ends drive the data bus");
    out_clk_mode_a: assert property ((c && c_n) || (c == k && c_n == k_n))
        else $error("output clocks neither held high nor following");
    read_burst_a: assert property ($rose(sram_dq_oe) |-> sram_dq_oe [*6] ##[1:6] !sram_dq_oe)
        else $error("read burst drive length wrong");
    first_echo_a: assert property ($rose(sram_dq_oe) |-> ##[0:3] echo_clk_pair[0])
        else $error("first read word without echo rise");
    echo_running_a: assert property (quiet < 4'ha)
        else $error("echo clock stopped");
endmodule : dbs_link_assertions

// >>> dv/ddr_burst2_sram_port_test.sv
/*
  ddr_burst2_sram_port_test: host end and memory end joined by the link,
  driven at the host command port and checked against a store model.
  assumes both ends share the 40 MHz clock; memory content starts unknown.
*/
`timescale 1ns/100ps
module ddr_burst2_sram_port_test;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic use_k_ref_in = 1'b0;
    logic cmd_valid_in = 1'b0;
    logic cmd_ready_out;
    logic cmd_write_in = 1'b0;
    logic [3:0] cmd_addr_in = 4'h0;
    logic [35:0] cmd_wdata_in = 36'h0;
    logic [3:0] cmd_mask_n_in = 4'hf;
    logic rd_valid_out;
    logic rd_ready_in = 1'b0;
    logic [35:0] rd_data_out;
    logic idle_cycle_out;
    logic k_ref_mode_out;
    logic [17:0] mem [16];
    logic [3:0] a;
    int seed = 20775;
    int fail_count = 0;
    int num_checks = 0;
    always #12.5 sys_clk_in = ~sys_clk_in;
    // ==========================================================
    // the link and both ends
    dbs_link_if dbs_link_if_inst ();
    dbs_host_end dbs_host_end_inst (.sys_clk_in, .rst_in, .use_k_ref_in, .cmd_valid_in,
        .cmd_ready_out, .cmd_write_in, .cmd_addr_in, .cmd_wdata_in, .cmd_mask_n_in,
        .rd_valid_out, .rd_ready_in, .rd_data_out, .link(dbs_link_if_inst.host));
    dbs_sram_end dbs_sram_end_inst (.sys_clk_in, .rst_in, .link(dbs_link_if_inst.sram),
        .idle_cycle_out, .k_ref_mode_out);
    dbs_link_assertions dbs_link_assertions_inst (.sys_clk_in, .rst_in,
        .k(dbs_link_if_inst.k), .k_n(dbs_link_if_inst.k_n), .c(dbs_link_if_inst.c),
        .c_n(dbs_link_if_inst.c_n), .cycle_define_n(dbs_link_if_inst.cycle_define_n),
        .read_sel(dbs_link_if_inst.read_sel), .addr(dbs_link_if_inst.addr),
        .lane_write_mask_n(dbs_link_if_inst.lane_write_mask_n),
        .echo_clk_pair(dbs_link_if_inst.echo_clk_pair), .host_dq_o(dbs_link_if_inst.host_dq_o),
        .host_dq_oe(dbs_link_if_inst.host_dq_oe), .sram_dq_oe(dbs_link_if_inst.sram_dq_oe));
    // ==========================================================
    // helpers
    function automatic logic [35:0] rnd36();
        return 36'({$random(seed), $random(seed)});
    endfunction : rnd36
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    // command held until the phase-5 ready; the model sees masked lanes kept
    task automatic send(input logic w, input logic [3:0] ad, input logic [35:0] d,
        input logic [3:0] m);
        int n = 0;
        // an edge passes first, so valid never falls and rises in one time step
        @(posedge sys_clk_in);
        #2;
        cmd_valid_in = 1'b1;
        cmd_write_in = w;
        cmd_addr_in = ad;
        cmd_wdata_in = d;
        cmd_mask_n_in = m;
        while (cmd_ready_out !== 1'b1 && n < 40) begin
            @(posedge sys_clk_in);
            #2;
            n++;
        end
        if (n >= 40) begin
            fail_count++;
        end
        @(posedge sys_clk_in);
        #2;
        cmd_valid_in = 1'b0;
        for (int i = 0; i < 2 && w; i++) begin
            for (int l = 0; l < 2; l++) begin
                if (!m[2*i+l]) begin
                    mem[ad ^ 4'(i)][9*l +: 9] = d[18*i+9*l +: 9];
                end
            end
        end
    endtask : send
    // the receiver stalls a random while; the word pair must stand meanwhile
    task automatic read_back(input logic [3:0] ad);
        int n = 0;
        send(1'b0, ad, rnd36(), 4'($random(seed)));
        while (rd_valid_out !== 1'b1 && n < 60) begin
            @(posedge sys_clk_in);
            #2;
            n++;
        end
        if (n >= 60) begin
            fail_count++;
        end
        check(rd_data_out, {mem[ad ^ 4'h1], mem[ad]});
        repeat ($unsigned($random(seed)) % 4) @(posedge sys_clk_in);
        #2;
        check({35'h0, rd_valid_out}, 36'h1);
        check(rd_data_out, {mem[ad ^ 4'h1], mem[ad]});
        rd_ready_in = 1'b1;
        @(posedge sys_clk_in);
        #2;
        rd_ready_in = 1'b0;
        check({35'h0, rd_valid_out}, 36'h0);
    endtask : read_back
    // ==========================================================
    // tests
    initial begin
        repeat (4) @(posedge sys_clk_in);
        #2;
        check({31'h0, dbs_link_if_inst.cycle_define_n, dbs_link_if_inst.host_dq_oe,
            dbs_link_if_inst.sram_dq_oe, idle_cycle_out, k_ref_mode_out}, 36'h12);
        rst_in = 1'b0;
        for (int i = 0; i < 16; i += 2) begin
            send(1'b1, 4'(i), rnd36(), 4'h0);
        end
        $display("test fill done");
        for (int m = 0; m < 16; m++) begin
            a = 4'($random(seed));
            send(1'b1, a, rnd36(), 4'(m));
            read_back(a);
        end
        $display("test masks done");
        repeat (20) @(posedge sys_clk_in);
        #2;
        check({34'h0, idle_cycle_out, k_ref_mode_out}, 36'h2);
        $display("test idle done");
        for (int r = 0; r < 2; r++) begin
            use_k_ref_in = (r == 0);
            repeat (24) @(posedge sys_clk_in);
            #2;
            check({35'h0, k_ref_mode_out}, 36'(r == 0));
            for (int i = 0; i < 4; i++) begin
                a = 4'($random(seed));
                send(1'b1, a, rnd36(), 4'($random(seed)));
                read_back(a);
            end
        end
        $display("test reference modes done");
        close_out();
    end
    // about 900 cycles of tests; nearly nine times that is a hang
    initial begin
        #200000;
        fail_count++;
        $display("watchdog expired at %0t", $time);
        close_out();
    end
endmodule : ddr_burst2_sram_port_test
